// ===== mci_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - start bit runs monitoring, clear means standby
// - clearing start keeps interrupt output asserted
// - start begins scanning; host programs limits first
// - enable bit gates interrupt output
// - hold bit deasserts interrupt, keeps status
// - hold bit halts monitoring until cleared
// - bit 4 gives 20 ms master pulse, self-clears
// - bit 6 gives 20 ms intrusion pulse, self-clears
// - bit 6 and release bit 7 shared
// - bit 7 restores defaults of listed registers
// - restore bit reads back zero
// - control register resets to hold only
// - voltage limit events set status bits
// - temperature event sets primary bit 4
// - tach limit events set bits 6, 7
// - intrusion input high sets secondary bit 4
// - under-temperature flag only in extended mode
// - primary mask bits block interrupt
// - master pulse needs secondary mask bit 7
module mci_ctrl
	import mci_pkg::*;
#(
	parameter int unsigned P_PULSE_CYCLES = PULSE_CYCLES
) (
	input wire logic i_clk, // 250 MHz core clock
	input wire logic i_rst_b, // async reset, active low
	input wire logic [7:0] i_addr, // register index
	input wire logic i_wr_en, // write strobe
	input wire logic [7:0] i_wdata, // write data
	input wire logic i_rd_en, // read strobe
	output logic [7:0] o_rdata, // read data, next cycle
	input wire logic [7:0] i_evt_pri, // primary limit events
	input wire logic [7:0] i_evt_sec, // secondary limit events
	input wire logic i_extended_mode, // extended mode active
	input wire logic i_intrusion_in, // intrusion pin level
	output logic o_intrusion_out, // intrusion pin drive value
	output logic o_intrusion_oe, // intrusion pin drive enable
	input wire logic i_master_rst_in, // master pulse pin level
	output logic o_master_rst_out, // master pulse drive value
	output logic o_master_rst_oe, // master pulse drive enable
	output logic o_int_b, // interrupt, active low
	output logic o_monitor_run, // scanning allowed
	output logic o_restore_defaults // restore pulse to others
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] a,
		input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	function automatic logic pending(input logic [7:0] st,
		input logic [7:0] mk, input logic [7:0] vld,
		input logic [7:0] mkv);
		pending = |(st & vld & ~(mk & mkv));
	endfunction

	// ------------------------------------------------------------
	// storage and decode
	// ------------------------------------------------------------
	logic [7:0] cfg_ff, nxt_cfg;
	logic [7:0] evt_pri_ff, nxt_evt_pri;
	logic [7:0] evt_sec_ff, nxt_evt_sec;
	logic [7:0] mask_pri_ff;
	logic [7:0] mask_sec_ff;
	logic [6:0] rel_low_ff;
	logic rel_bit_ff, nxt_rel_bit;
	logic int_b_ff;
	logic [7:0] rdata_ff;
	logic restore_ff;
	logic wr_cfg, wr_mpri, wr_msec, wr_rel;
	logic rd_pri, rd_sec;
	logic restore_hit;
	logic run;
	logic [7:0] set_pri, set_sec;
	logic any_pend;

	mci_pulse_if mrst_if ();
	mci_pulse_if rel_if ();

	assign wr_cfg = i_wr_en && reg_hit(i_addr, MON_CTRL_OFF);
	assign wr_mpri = i_wr_en && reg_hit(i_addr, MASK_PRI_OFF);
	assign wr_msec = i_wr_en && reg_hit(i_addr, MASK_SEC_OFF);
	assign wr_rel = i_wr_en && reg_hit(i_addr, INTR_REL_OFF);
	assign rd_pri = i_rd_en && reg_hit(i_addr, EVT_PRI_OFF);
	assign rd_sec = i_rd_en && reg_hit(i_addr, EVT_SEC_OFF);
	assign restore_hit = wr_cfg && i_wdata[RESTORE_BIT];

	// scanning needs start set and hold clear
	assign run = cfg_ff[START_BIT] && !cfg_ff[HOLD_BIT];
	assign o_monitor_run = run;

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_comb begin
		nxt_cfg = cfg_ff;
		if (mrst_if.done) begin
			nxt_cfg[MRST_BIT] = 1'b0;
		end
		if (wr_cfg) begin
			nxt_cfg = i_wdata;
			// a zero write cannot cut a pulse short
			nxt_cfg[MRST_BIT] = (cfg_ff[MRST_BIT] && !mrst_if.done)
				|| (i_wdata[MRST_BIT]
				&& mask_sec_ff[MRST_EN_BIT]);
			nxt_cfg[REL_BIT] = 1'b0;
			nxt_cfg[RESTORE_BIT] = 1'b0;
		end
		if (restore_hit) begin
			nxt_cfg = MON_CTRL_RST;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_ff <= MON_CTRL_RST;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	// ------------------------------------------------------------
	// shared intrusion release bit
	// ------------------------------------------------------------
	always_comb begin
		nxt_rel_bit = rel_bit_ff && !rel_if.done;
		// a new request in the done cycle wins
		if ((wr_cfg && i_wdata[REL_BIT])
			|| (wr_rel && i_wdata[REL_MIRROR_BIT])) begin
			nxt_rel_bit = 1'b1;
		end
		if (restore_hit) begin
			nxt_rel_bit = INTR_REL_RST[REL_MIRROR_BIT];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rel_bit_ff <= INTR_REL_RST[REL_MIRROR_BIT];
		end else begin
			rel_bit_ff <= nxt_rel_bit;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rel_low_ff <= INTR_REL_RST[6:0];
		end else if (restore_hit) begin
			rel_low_ff <= INTR_REL_RST[6:0];
		end else if (wr_rel) begin
			rel_low_ff <= i_wdata[6:0];
		end
	end

	// ------------------------------------------------------------
	// mask registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mask_pri_ff <= MASK_PRI_RST;
			mask_sec_ff <= MASK_SEC_RST;
		end else if (restore_hit) begin
			mask_pri_ff <= MASK_PRI_RST;
			mask_sec_ff <= MASK_SEC_RST;
		end else begin
			if (wr_mpri) begin
				mask_pri_ff <= i_wdata;
			end
			if (wr_msec) begin
				mask_sec_ff <= i_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// event status, sticky, cleared by reading
	// ------------------------------------------------------------
	// measurement events only count while scanning
	assign set_pri = i_evt_pri & PRI_EVT_VALID
		& {8{run}};

	always_comb begin
		set_sec = i_evt_sec & SEC_MEAS_BITS & {8{run}};
		// intrusion is watched even in standby
		set_sec[INTR_EVT_BIT] = i_intrusion_in;
		set_sec[UNDER_TEMP_BIT] = i_evt_sec[UNDER_TEMP_BIT] && run
			&& i_extended_mode;
	end

	// hold does not touch status contents
	assign nxt_evt_pri = (rd_pri ? EVT_PRI_RST : evt_pri_ff)
		| set_pri;
	assign nxt_evt_sec = (rd_sec ? EVT_SEC_RST : evt_sec_ff)
		| set_sec;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			evt_pri_ff <= EVT_PRI_RST;
			evt_sec_ff <= EVT_SEC_RST;
		end else if (restore_hit) begin
			evt_pri_ff <= EVT_PRI_RST;
			evt_sec_ff <= EVT_SEC_RST;
		end else begin
			evt_pri_ff <= nxt_evt_pri;
			evt_sec_ff <= nxt_evt_sec;
		end
	end

	// ------------------------------------------------------------
	// interrupt output
	// ------------------------------------------------------------
	assign any_pend = pending(evt_pri_ff, mask_pri_ff, PRI_EVT_VALID,
		PRI_MASK_VALID)
		|| pending(evt_sec_ff, mask_sec_ff, SEC_EVT_VALID,
		SEC_MASK_VALID);

	// start is not a term: standby keeps a raised interrupt
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			int_b_ff <= 1'b1;
		end else begin
			int_b_ff <= !(cfg_ff[INT_EN_BIT] && !cfg_ff[HOLD_BIT]
				&& any_pend);
		end
	end

	assign o_int_b = int_b_ff;

	// ------------------------------------------------------------
	// pulse generators
	// ------------------------------------------------------------
	assign mrst_if.req = cfg_ff[MRST_BIT] && !mrst_if.active;
	assign mrst_if.abort = restore_hit;
	assign rel_if.req = rel_bit_ff && !rel_if.active;
	assign rel_if.abort = restore_hit;

	mci_pulse #(
		.CYCLES(P_PULSE_CYCLES)
	) u_mrst_pulse (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.pif(mrst_if)
	);

	mci_pulse #(
		.CYCLES(P_PULSE_CYCLES)
	) u_rel_pulse (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.pif(rel_if)
	);

	// open-drain: drive low only while the pulse runs
	assign o_master_rst_out = 1'b0;
	assign o_master_rst_oe = mrst_if.active;
	assign o_intrusion_out = 1'b0;
	assign o_intrusion_oe = rel_if.active;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			restore_ff <= 1'b0;
		end else begin
			restore_ff <= restore_hit;
		end
	end

	assign o_restore_defaults = restore_ff;

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_ff <= 8'h00;
		end else if (i_rd_en) begin
			case (i_addr)
				MON_CTRL_OFF: rdata_ff <= {cfg_ff[7], rel_bit_ff,
					cfg_ff[5:0]};
				EVT_PRI_OFF: rdata_ff <= evt_pri_ff;
				EVT_SEC_OFF: rdata_ff <= evt_sec_ff;
				MASK_PRI_OFF: rdata_ff <= mask_pri_ff;
				MASK_SEC_OFF: rdata_ff <= mask_sec_ff;
				INTR_REL_OFF: rdata_ff <= {rel_bit_ff,
					rel_low_ff};
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	assign o_rdata = rdata_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_run_from_start: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(wr_cfg && !restore_hit && i_wdata[START_BIT]
			&& !i_wdata[HOLD_BIT]) |=> o_monitor_run
	) else $error("start write did not begin monitoring");

	a_standby_keeps_int: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(!o_int_b && any_pend && wr_cfg && !restore_hit
			&& !i_wdata[START_BIT] && i_wdata[INT_EN_BIT]
			&& !i_wdata[HOLD_BIT] && cfg_ff[INT_EN_BIT]
			&& !cfg_ff[HOLD_BIT] && !i_rd_en)
			|=> ##1 !o_int_b
	) else $error("clearing start dropped the interrupt");

	a_int_enable_gate: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		!cfg_ff[INT_EN_BIT] |=> o_int_b
	) else $error("interrupt driven while disabled");

	a_hold_releases_int: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		cfg_ff[HOLD_BIT] |=> o_int_b
	) else $error("interrupt driven while held");

	a_hold_keeps_status: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(wr_cfg && i_wdata[HOLD_BIT] && !restore_hit && !i_rd_en)
			|=> (evt_pri_ff & $past(evt_pri_ff)) == $past(evt_pri_ff)
	) else $error("hold write changed status bits");

	a_hold_stops_scan: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(cfg_ff[HOLD_BIT] && !i_rd_en && !restore_hit)
			|=> evt_pri_ff == $past(evt_pri_ff)
	) else $error("monitoring while held");

	a_mrst_self_clear: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		($fell(o_master_rst_oe) && !$past(wr_cfg)) |-> !cfg_ff[MRST_BIT]
	) else $error("master pulse bit stayed set after pulse");

	a_rel_self_clear: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		($fell(o_intrusion_oe) && !$past(wr_cfg) && !$past(wr_rel))
			|-> !rel_bit_ff
	) else $error("release bit stayed set after pulse");

	a_rel_mirror_read: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_rd_en && i_addr == MON_CTRL_OFF)
			|=> o_rdata[REL_BIT] == $past(rel_bit_ff)
	) else $error("release mirror mismatch");

	a_restore_values: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		restore_hit |=> (cfg_ff == MON_CTRL_RST
			&& mask_pri_ff == MASK_PRI_RST && evt_sec_ff == EVT_SEC_RST
			&& !rel_bit_ff && o_restore_defaults)
	) else $error("restore did not reload defaults");

	a_volt_evt_sets: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_evt_pri[0] && run && !restore_hit) |=> evt_pri_ff[0]
	) else $error("voltage event lost");

	a_under_temp_ext: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		$rose(evt_sec_ff[UNDER_TEMP_BIT]) |-> $past(i_extended_mode)
	) else $error("under-temperature flag outside extended mode");

	a_mask_blocks_int: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		!any_pend |=> o_int_b
	) else $error("interrupt with all events masked");

	a_mrst_needs_en: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(!o_master_rst_oe && !cfg_ff[MRST_BIT]
			&& !mask_sec_ff[MRST_EN_BIT]) |=> ##1 !o_master_rst_oe
	) else $error("master pulse without its enable");

	a_int_asserts: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(cfg_ff[INT_EN_BIT] && !cfg_ff[HOLD_BIT] && any_pend)
			|=> !o_int_b
	) else $error("interrupt not asserted");

endmodule // mci_ctrl

// ===== mci_pkg.sv
package mci_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] MON_CTRL_OFF = 8'h40;
	localparam logic [7:0] EVT_PRI_OFF = 8'h41;
	localparam logic [7:0] EVT_SEC_OFF = 8'h42;
	localparam logic [7:0] MASK_PRI_OFF = 8'h43;
	localparam logic [7:0] MASK_SEC_OFF = 8'h44;
	localparam logic [7:0] INTR_REL_OFF = 8'h46;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MON_CTRL_RST = 8'h08;
	localparam logic [7:0] EVT_PRI_RST = 8'h00;
	localparam logic [7:0] EVT_SEC_RST = 8'h00;
	localparam logic [7:0] MASK_PRI_RST = 8'h00;
	localparam logic [7:0] MASK_SEC_RST = 8'h00;
	localparam logic [7:0] INTR_REL_RST = 8'h00;

	// ------------------------------------------------------------
	// field positions and valid-bit sets
	// ------------------------------------------------------------
	localparam int unsigned START_BIT = 0;
	localparam int unsigned INT_EN_BIT = 1;
	localparam int unsigned HOLD_BIT = 3;
	localparam int unsigned MRST_BIT = 4;
	localparam int unsigned REL_BIT = 6;
	localparam int unsigned RESTORE_BIT = 7;
	localparam int unsigned REL_MIRROR_BIT = 7;
	localparam int unsigned MRST_EN_BIT = 7;
	localparam int unsigned INTR_EVT_BIT = 4;
	localparam int unsigned UNDER_TEMP_BIT = 7;
	localparam logic [7:0] PRI_EVT_VALID = 8'hDF;
	localparam logic [7:0] SEC_EVT_VALID = 8'h93;
	localparam logic [7:0] SEC_MEAS_BITS = 8'h03;
	localparam logic [7:0] PRI_MASK_VALID = 8'hDF;
	localparam logic [7:0] SEC_MASK_VALID = 8'h13;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned PULSE_TIME_MS = 20;
	localparam int unsigned CLK_FREQ_KHZ = 250000;
	localparam int unsigned PULSE_CYCLES = PULSE_TIME_MS * CLK_FREQ_KHZ;
	localparam int unsigned CNT_W = 23;

	typedef enum logic [1:0] {
		P_IDLE = 2'b01,
		P_BUSY = 2'b10
	} mci_pulse_state_type;

endpackage

// ===== mci_pulse_if.sv
`timescale 1ns/1ps
interface mci_pulse_if;
	logic req;
	logic abort;
	logic active;
	logic done;

	modport gen (
		input req,
		input abort,
		output active,
		output done
	);

	modport ctl (
		output req,
		output abort,
		input active,
		input done
	);
endinterface

// ===== mci_pulse.sv
`timescale 1ns/1ps
module mci_pulse
	import mci_pkg::*;
#(
	parameter int unsigned CYCLES = PULSE_CYCLES
) (
	input wire logic i_clk, // core clock
	input wire logic i_rst_b, // async reset, active low
	mci_pulse_if.gen pif // request and status
);

	mci_pulse_state_type st_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic last;

	assign last = (cnt_ff == CNT_W'(CYCLES - 1));
	assign pif.active = (st_ff == P_BUSY);
	assign pif.done = pif.active && last && !pif.abort;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff <= P_IDLE;
		end else if (pif.abort) begin
			st_ff <= P_IDLE;
		end else begin
			unique case (st_ff)
				P_IDLE: if (pif.req) st_ff <= P_BUSY;
				P_BUSY: if (last) st_ff <= P_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_ff <= '0;
		end else if (pif.abort || st_ff == P_IDLE) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	a_pulse_full_len: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(st_ff == P_BUSY && !pif.abort && !last) |=> st_ff == P_BUSY
	) else $error("pulse ended before its full length");

	a_pulse_ends: assert property (
		@(posedge i_clk) disable iff (!i_rst_b)
		(st_ff == P_BUSY && last) |=> st_ff == P_IDLE
	) else $error("pulse outlived its count");

endmodule // mci_pulse

// ===== mci_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// register port host, one strobe cycle per access
// ------------------------------------------------------------
module mci_host_model (
	input wire logic i_clk, // core clock
	input wire logic [7:0] i_rdata, // read data from block
	output logic [7:0] o_addr, // register index
	output logic o_wr_en, // write strobe
	output logic [7:0] o_wdata, // write data
	output logic o_rd_en // read strobe
);
	initial begin
		o_addr = 8'h00;
		o_wr_en = 1'b0;
		o_wdata = 8'h00;
		o_rd_en = 1'b0;
	end

	// released lines flip so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_wr_en = 1'b1;
		@(negedge i_clk);
		o_wr_en = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_rd_en = 1'b1;
		@(negedge i_clk);
		o_rd_en = 1'b0;
		o_addr = ~a;
		d = i_rdata;
	endtask
endmodule // mci_host_model

// ===== monitor_config_and_interrupt_regs_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	$display("unexpected %s expected %h seen %h", nm, e, g); \
	fail_count++; end end
module monitor_config_and_interrupt_regs_test;
	import mci_pkg::*;
	localparam int unsigned PC = 8;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [7:0] addr, wdata, rdata, evt_pri, evt_sec;
	logic wr_en, rd_en, ext_mode, ci_ext;
	logic ci_out, ci_oe, ms_out, ms_oe, int_b, run, restore;
	int fail_count = 0;
	int checks_done = 0;
	int ms_cnt = 0;
	int ci_cnt = 0;
	int rs_cnt = 0;

	always #2 i_clk = ~i_clk;

	// ------------------------------------------------------------
	// block, host and open-drain pins
	// ------------------------------------------------------------
	mci_host_model host_u (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
		.o_wr_en(wr_en), .o_wdata(wdata), .o_rd_en(rd_en));
	mci_ctrl #(.P_PULSE_CYCLES(PC)) dut_u (.i_clk(i_clk),
		.i_rst_b(i_rst_b), .i_addr(addr), .i_wr_en(wr_en),
		.i_wdata(wdata), .i_rd_en(rd_en), .o_rdata(rdata),
		.i_evt_pri(evt_pri), .i_evt_sec(evt_sec),
		.i_extended_mode(ext_mode), .i_intrusion_in(ci_ext & ~ci_oe),
		.o_intrusion_out(ci_out), .o_intrusion_oe(ci_oe),
		.i_master_rst_in(~ms_oe), .o_master_rst_out(ms_out),
		.o_master_rst_oe(ms_oe), .o_int_b(int_b), .o_monitor_run(run),
		.o_restore_defaults(restore));

	always @(posedge i_clk) begin
		if (ms_oe === 1'b1) ms_cnt++;
		if (ci_oe === 1'b1) ci_cnt++;
		if (restore === 1'b1) rs_cnt++;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		logic [7:0] v;
		host_u.rd(a, v);
		`CHK(nm, e, v)
	endtask

	// one-cycle event pulse
	task automatic evt(input logic [7:0] p, input logic [7:0] s);
		@(negedge i_clk);
		evt_pri = p;
		evt_sec = s;
		@(negedge i_clk);
		evt_pri = 8'h00;
		evt_sec = 8'h00;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rdc(MON_CTRL_OFF, 8'h08, "ctrl");
		rdc(EVT_PRI_OFF, 8'h00, "evt_pri");
		rdc(MASK_PRI_OFF, 8'h00, "mask_pri");
		rdc(8'h50, 8'h00, "unmapped");
		`CHK("run", 1'b0, run)
		`CHK("int_b", 1'b1, int_b)
	endtask

	task automatic t_events();
		// limits live outside; start is the last setting made
		host_u.wr(MON_CTRL_OFF, 8'h03);
		`CHK("run", 1'b1, run)
		for (int i = 0; i < 8; i++) begin
			evt(8'h01 << i, 8'h00);
			rdc(EVT_PRI_OFF, (8'h01 << i) & PRI_EVT_VALID, "evt");
		end
		host_u.wr(EVT_PRI_OFF, 8'hFF);
		rdc(EVT_PRI_OFF, 8'h00, "evt_ro");
	endtask

	task automatic t_irq();
		evt(8'h01, 8'h00);
		cyc(1);
		`CHK("int_b", 1'b0, int_b)
		host_u.wr(MON_CTRL_OFF, 8'h02);
		cyc(1);
		`CHK("int_b", 1'b0, int_b)
		host_u.wr(MON_CTRL_OFF, 8'h0B);
		cyc(1);
		`CHK("int_b", 1'b1, int_b)
		`CHK("run", 1'b0, run)
		evt(8'h02, 8'h00);
		rdc(EVT_PRI_OFF, 8'h01, "evt_held");
		host_u.wr(MON_CTRL_OFF, 8'h01);
		`CHK("run", 1'b1, run)
		evt(8'h01, 8'h00);
		cyc(1);
		`CHK("int_b", 1'b1, int_b)
		rdc(EVT_PRI_OFF, 8'h01, "evt_dis");
	endtask

	task automatic t_mask();
		host_u.wr(MON_CTRL_OFF, 8'h03);
		host_u.wr(MASK_PRI_OFF, 8'h01);
		evt(8'h01, 8'h00);
		cyc(1);
		`CHK("int_b", 1'b1, int_b)
		evt(8'h02, 8'h00);
		cyc(1);
		`CHK("int_b", 1'b0, int_b)
		rdc(EVT_PRI_OFF, 8'h03, "evt_mask");
		rdc(MASK_PRI_OFF, 8'h01, "mask_pri");
	endtask

	task automatic t_sec();
		evt(8'h00, 8'h80);
		rdc(EVT_SEC_OFF, 8'h00, "under_temp_off");
		ext_mode = 1'b1;
		evt(8'h00, 8'h80);
		rdc(EVT_SEC_OFF, 8'h80, "under_temp_on");
		evt(8'h00, 8'h01);
		rdc(EVT_SEC_OFF, 8'h01, "evt_sec");
		ci_ext = 1'b1;
		cyc(1);
		ci_ext = 1'b0;
		rdc(EVT_SEC_OFF, 8'h10, "intrusion");
		host_u.wr(MASK_SEC_OFF, 8'h10);
		ci_ext = 1'b1;
		cyc(1);
		ci_ext = 1'b0;
		cyc(1);
		`CHK("int_b_msk2", 1'b1, int_b)
		rdc(EVT_SEC_OFF, 8'h10, "intr_masked");
	endtask

	task automatic t_pulse();
		ms_cnt = 0;
		host_u.wr(MON_CTRL_OFF, 8'h13);
		cyc(PC + 4);
		`CHK("ms_cnt_off", 0, ms_cnt)
		rdc(MON_CTRL_OFF, 8'h03, "ctrl_off");
		host_u.wr(MASK_SEC_OFF, 8'h80);
		host_u.wr(MON_CTRL_OFF, 8'h13);
		cyc(2);
		`CHK("ms_oe", 1'b1, ms_oe)
		`CHK("ms_out", 1'b0, ms_out)
		cyc(PC + 2);
		`CHK("ms_cnt", PC, ms_cnt)
		rdc(MON_CTRL_OFF, 8'h03, "ctrl_ms");
		ci_cnt = 0;
		host_u.wr(INTR_REL_OFF, 8'h80);
		rdc(MON_CTRL_OFF, 8'h43, "ctrl_mirror");
		`CHK("ci_oe", 1'b1, ci_oe)
		`CHK("ci_out", 1'b0, ci_out)
		cyc(PC + 4);
		`CHK("ci_cnt", PC, ci_cnt)
		rdc(INTR_REL_OFF, 8'h00, "rel");
		rdc(EVT_SEC_OFF, 8'h00, "intr_quiet");
	endtask

	task automatic t_restore();
		host_u.wr(MASK_PRI_OFF, 8'hFF);
		// a running release pulse and a raised flag must both go
		host_u.wr(INTR_REL_OFF, 8'h80);
		evt(8'h01, 8'h00);
		rs_cnt = 0;
		host_u.wr(MON_CTRL_OFF, 8'h83);
		cyc(2);
		`CHK("restore", 1, rs_cnt)
		`CHK("ci_oe_abort", 1'b0, ci_oe)
		rdc(EVT_PRI_OFF, 8'h00, "evt_rst");
		rdc(INTR_REL_OFF, 8'h00, "rel_rst");
		rdc(MON_CTRL_OFF, 8'h08, "ctrl_rst");
		rdc(MASK_PRI_OFF, 8'h00, "mask_rst");
		rdc(MASK_SEC_OFF, 8'h00, "mask2_rst");
	endtask

	// ------------------------------------------------------------
	// run
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		evt_pri = 8'h00;
		evt_sec = 8'h00;
		ext_mode = 1'b0;
		ci_ext = 1'b0;
		repeat (16) @(negedge i_clk);
		i_rst_b = 1'b1;
		t_reset();
		t_events();
		t_irq();
		t_mask();
		t_sec();
		t_pulse();
		t_restore();
		conclude();
	end

	// hang guard well past the whole sequence
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule // monitor_config_and_interrupt_regs_test
